// file: hw/tpa_map.vh
// Purpose: Register indices, field positions and reset values of the timer pulse accumulator block
// Assumes: Byte address of a register is four times its index; data sits in the low bits
// Notes: Definitions only
`ifndef TPA_MAP_VH
`define TPA_MAP_VH

// Register indices (byte address = index * 4)
`define TPA_IDX_CH6 8'h9C
`define TPA_IDX_CH7 8'h9E
`define TPA_IDX_ACC_CTRL 8'hA0
`define TPA_IDX_ACC_FLAGS 8'hA1
`define TPA_IDX_ACC_COUNT 8'hA2
`define TPA_IDX_TEST 8'hAD
`define TPA_IDX_PORT_DATA 8'hAE
`define TPA_IDX_PORT_DIR 8'hAF

// Accumulator control fields
`define TPA_CTRL_ENABLE 6
`define TPA_CTRL_MODE 5
`define TPA_CTRL_EDGE 4
`define TPA_CTRL_CLK_HI 3
`define TPA_CTRL_CLK_LO 2
`define TPA_CTRL_OVF_IRQ 1
`define TPA_CTRL_IN_IRQ 0

// Accumulator flag fields
`define TPA_FLAG_OVF 1
`define TPA_FLAG_IN 0

// Test control fields
`define TPA_TEST_CNT_BYP 1
`define TPA_TEST_ACC_BYP 0

// Counter clock select codes
`define TPA_CLKSEL_PRESC 2'b00
`define TPA_CLKSEL_ACC 2'b01
`define TPA_CLKSEL_ACC256 2'b10
`define TPA_CLKSEL_ACC64K 2'b11

// Reset values
`define TPA_RST_WORD16 16'h0000
`define TPA_RST_BYTE 8'h00

`endif

// file: hw/tpa_top.v
// Purpose: Upper capture/compare channels, pulse accumulator, counter clock select, test bypass and timer port
// Assumes: AHB-Lite single word transfers; one wait state on every access; 40 MHz sys_clk_i
// Notes: Prescaler and divide-by-64 ticks arrive as one-cycle enables from the rest of the timer
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tpa_map.vh"

//Behaviour
//- Channel captures counter or compares per select
//- Channel writes ignored while in capture
//- Accumulator enable switches accumulator, independent of timer
//- Mode bit: 0 events, 1 gated time
//- Event mode counts falling or rising edges
//- Gated mode gates div64 clock, trailing edge flags
//- No div64 clock while timer disabled
//- Clock select picks counter clock source
//- Accumulator disabled forces prescaler counter clock
//- Clock select change acts immediately
//- Flag with enable raises interrupt request
//- Fast clear: count access clears both flags
//- Overflow flag on wrap, bit1 write clears
//- Input flag on edge, bit0 write clears
//- Test register writable only in special mode
//- Bypass bits split counters into 8-bit halves
//- Port read: pin level or driver level
//- Port latch drives only general outputs
//- Direction bit; enabled compare forces output
//- Stop, debug with its stop bit, wait with its stop bit and enables halt operation
module tpa_top #(
  parameter ADDR_W = 12
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [ADDR_W-1:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // Links to the rest of the timer
  input wire prescaler_tick_i,
  input wire div64_tick_i,
  input wire timer_enable_i,
  input wire fast_flag_clear_i,
  input wire [1:0] capture_compare_select_i,
  input wire [1:0] capture_event_i,
  input wire [7:0] compare_output_enable_i,
  input wire [7:0] compare_output_level_i,
  // Chip modes
  input wire special_mode_n_i,
  input wire stop_mode_i,
  input wire wait_mode_i,
  input wire debug_mode_i,
  input wire debug_stop_bit_i,
  input wire wait_stop_bit_i,
  // Results
  output reg [15:0] counter_value_o,
  output reg [1:0] compare_match_o,
  output reg accumulator_overflow_irq_o,
  output reg accumulator_input_irq_o,
  // Timer port pins
  input wire [7:0] port_pin_i,
  output reg [7:0] port_pin_o,
  output reg [7:0] port_pin_oe_o
);

  // Byte lane wide increment with optional split into halves
  function [15:0] inc16;
    input [15:0] val;
    input split;
    begin
      if (split) begin
        inc16 = {val[15:8] + 8'h01, val[7:0] + 8'h01};
      end else begin
        inc16 = val + 16'h0001;
      end
    end
  endfunction

  // Registers
  reg [15:0] channel6_capture_compare; // Channel 6 value
  reg [15:0] channel7_capture_compare; // Channel 7 value
  reg [7:0] accumulator_control; // Enable, mode, edge, clock select, irq enables
  reg [1:0] accumulator_flags; // Overflow and input edge flags
  reg [15:0] accumulator_count; // Pulse accumulator
  reg [1:0] timer_test_control; // Bypass bits
  reg [7:0] port_data_latch; // Port output latch
  reg [7:0] port_direction; // 1 = output

  // Bus state
  reg bus_pend; // Data phase pending
  reg bus_write; // Pending access is a write
  reg [7:0] bus_idx; // Pending register index
  reg [7:0] pin_meta; // First synchroniser stage
  reg [7:0] pin_sync; // Second synchroniser stage
  reg acc_pin_last; // Previous synced accumulator input
  reg count_ticked; // Main counter advanced last cycle

  // Decoded control bits
  wire acc_enable = accumulator_control[`TPA_CTRL_ENABLE];
  wire acc_mode = accumulator_control[`TPA_CTRL_MODE];
  wire acc_edge = accumulator_control[`TPA_CTRL_EDGE];
  wire [1:0] clk_sel = {accumulator_control[`TPA_CTRL_CLK_HI], accumulator_control[`TPA_CTRL_CLK_LO]};
  wire cnt_byp = timer_test_control[`TPA_TEST_CNT_BYP];
  wire acc_byp = timer_test_control[`TPA_TEST_ACC_BYP];

  // Mode freezes common to both halves of the timer
  wire mode_halt = stop_mode_i | (debug_mode_i & debug_stop_bit_i) | (wait_mode_i & wait_stop_bit_i);
  wire timer_run = timer_enable_i & ~mode_halt;
  wire acc_run = acc_enable & ~mode_halt;

  // Accumulator input edge detection on synced pin
  wire acc_pin = pin_sync[7];
  wire rise = acc_pin & ~acc_pin_last;
  wire fall = ~acc_pin & acc_pin_last;
  wire sel_edge = acc_edge ? rise : fall;
  wire gate_open = acc_edge ? ~acc_pin : acc_pin;
  wire div64_ok = div64_tick_i & timer_run;

  // Accumulator clock tick
  wire acc_tick = acc_run & (acc_mode ? (gate_open & div64_ok) : sel_edge);
  wire acc_wrap = acc_byp ? (accumulator_count[15:8] == 8'hFF) : (accumulator_count == 16'hFFFF);
  wire acc_ovf = acc_tick & acc_wrap;
  wire acc_low_wrap = acc_tick & (accumulator_count[7:0] == 8'hFF);
  wire in_flag_set = acc_run & sel_edge;

  // Main counter clock source, combinational so a new select acts at once
  reg count_tick;
  always @* begin
    if (!timer_run) begin
      count_tick = 1'b0;
    end else if (cnt_byp) begin
      count_tick = 1'b1;
    end else if (!acc_enable) begin
      count_tick = prescaler_tick_i;
    end else begin
      case (clk_sel)
        `TPA_CLKSEL_PRESC: count_tick = prescaler_tick_i;
        `TPA_CLKSEL_ACC: count_tick = acc_tick;
        `TPA_CLKSEL_ACC256: count_tick = acc_low_wrap;
        `TPA_CLKSEL_ACC64K: count_tick = acc_ovf;
        default: count_tick = prescaler_tick_i;
      endcase
    end
  end

  // Access strobes of the pending data phase
  wire do_wr = bus_pend & bus_write;
  wire wr_ch6 = do_wr & (bus_idx == `TPA_IDX_CH6) & capture_compare_select_i[0];
  wire wr_ch7 = do_wr & (bus_idx == `TPA_IDX_CH7) & capture_compare_select_i[1];
  wire wr_ctrl = do_wr & (bus_idx == `TPA_IDX_ACC_CTRL);
  wire wr_flags = do_wr & (bus_idx == `TPA_IDX_ACC_FLAGS);
  wire wr_count = do_wr & (bus_idx == `TPA_IDX_ACC_COUNT);
  wire wr_test = do_wr & (bus_idx == `TPA_IDX_TEST) & ~special_mode_n_i;
  wire wr_data = do_wr & (bus_idx == `TPA_IDX_PORT_DATA);
  wire wr_dir = do_wr & (bus_idx == `TPA_IDX_PORT_DIR);
  wire count_access = bus_pend & (bus_idx == `TPA_IDX_ACC_COUNT);
  wire fast_clr = fast_flag_clear_i & count_access;

  // Pin driver input level and direction
  reg [7:0] next_pin_out;
  reg [7:0] next_pin_oe;
  integer k;
  always @* begin
    next_pin_out = 8'h00;
    next_pin_oe = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      if (compare_output_enable_i[k]) begin
        next_pin_out[k] = compare_output_level_i[k];
        next_pin_oe[k] = 1'b1;
      end else begin
        next_pin_out[k] = port_data_latch[k];
        next_pin_oe[k] = port_direction[k];
      end
    end
  end

  // Read multiplexer
  reg [31:0] next_rdata;
  always @* begin
    case (bus_idx)
      `TPA_IDX_CH6: next_rdata = {16'h0000, channel6_capture_compare};
      `TPA_IDX_CH7: next_rdata = {16'h0000, channel7_capture_compare};
      `TPA_IDX_ACC_CTRL: next_rdata = {24'h0000_00, accumulator_control};
      `TPA_IDX_ACC_FLAGS: next_rdata = {30'h0000_0000, accumulator_flags};
      `TPA_IDX_ACC_COUNT: next_rdata = {16'h0000, accumulator_count};
      `TPA_IDX_TEST: next_rdata = {30'h0000_0000, timer_test_control};
      // Outputs read driver level, inputs read the pin
      `TPA_IDX_PORT_DATA: next_rdata = {24'h0000_00, (port_pin_oe_o & port_pin_o) | (~port_pin_oe_o & pin_sync)};
      `TPA_IDX_PORT_DIR: next_rdata = {24'h0000_00, port_direction};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // AHB-Lite slave: address phase taken, one wait state, then answer
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_pend <= 1'b0;
      bus_write <= 1'b0;
      bus_idx <= `TPA_RST_BYTE;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0; // Always OKAY
      if (bus_pend) begin
        // Data phase completes with fresh read data
        bus_pend <= 1'b0;
        hreadyout_o <= 1'b1;
        hrdata_o <= bus_write ? 32'h0000_0000 : next_rdata;
      end else if (hsel_i & htrans_i[1] & hready_i) begin
        // Address phase taken; stretch data phase one cycle
        bus_pend <= 1'b1;
        bus_write <= hwrite_i;
        bus_idx <= haddr_i[9:2];
        hreadyout_o <= 1'b0;
      end
    end
  end

  // Control and test registers
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accumulator_control <= `TPA_RST_BYTE;
      timer_test_control <= 2'b00;
      port_data_latch <= `TPA_RST_BYTE;
      port_direction <= `TPA_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        accumulator_control <= {1'b0, hwdata_i[6:0]};
      end
      if (wr_test) begin
        timer_test_control <= hwdata_i[1:0];
      end
      if (wr_data) begin
        port_data_latch <= hwdata_i[7:0];
      end
      if (wr_dir) begin
        port_direction <= hwdata_i[7:0];
      end
    end
  end

  // Pulse accumulator and its flags
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accumulator_count <= `TPA_RST_WORD16;
      accumulator_flags <= 2'b00;
      acc_pin_last <= 1'b0;
    end else begin
      acc_pin_last <= acc_pin;
      // Software write replaces the count
      if (wr_count) begin
        accumulator_count <= hwdata_i[15:0];
      end else if (acc_tick) begin
        accumulator_count <= inc16(accumulator_count, acc_byp);
      end
      // Overflow flag: set beats clear, zero bits leave it
      if (acc_ovf) begin
        accumulator_flags[`TPA_FLAG_OVF] <= 1'b1;
      end else if (fast_clr | (wr_flags & hwdata_i[`TPA_FLAG_OVF])) begin
        accumulator_flags[`TPA_FLAG_OVF] <= 1'b0;
      end
      // Input edge flag: set beats clear
      if (in_flag_set) begin
        accumulator_flags[`TPA_FLAG_IN] <= 1'b1;
      end else if (fast_clr | (wr_flags & hwdata_i[`TPA_FLAG_IN])) begin
        accumulator_flags[`TPA_FLAG_IN] <= 1'b0;
      end
    end
  end

  // Main counter and channels 6 and 7
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_value_o <= `TPA_RST_WORD16;
      channel6_capture_compare <= `TPA_RST_WORD16;
      channel7_capture_compare <= `TPA_RST_WORD16;
      compare_match_o <= 2'b00;
      count_ticked <= 1'b0;
    end else begin
      count_ticked <= count_tick;
      if (count_tick) begin
        counter_value_o <= inc16(counter_value_o, cnt_byp);
      end
      // Channel 6: write in compare, capture in capture
      if (wr_ch6) begin
        channel6_capture_compare <= hwdata_i[15:0];
      end else if (!capture_compare_select_i[0] & capture_event_i[0] & timer_run) begin
        channel6_capture_compare <= counter_value_o;
      end
      // Channel 7
      if (wr_ch7) begin
        channel7_capture_compare <= hwdata_i[15:0];
      end else if (!capture_compare_select_i[1] & capture_event_i[1] & timer_run) begin
        channel7_capture_compare <= counter_value_o;
      end
      // Compare match pulses once per new counter value
      compare_match_o[0] <= capture_compare_select_i[0] & count_ticked
                            & (counter_value_o == channel6_capture_compare);
      compare_match_o[1] <= capture_compare_select_i[1] & count_ticked
                            & (counter_value_o == channel7_capture_compare);
    end
  end

  // Interrupt requests, pin drivers and input synchroniser
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accumulator_overflow_irq_o <= 1'b0;
      accumulator_input_irq_o <= 1'b0;
      port_pin_o <= `TPA_RST_BYTE;
      port_pin_oe_o <= `TPA_RST_BYTE;
      pin_meta <= `TPA_RST_BYTE;
      pin_sync <= `TPA_RST_BYTE;
    end else begin
      accumulator_overflow_irq_o <= accumulator_flags[`TPA_FLAG_OVF]
                                    & accumulator_control[`TPA_CTRL_OVF_IRQ];
      accumulator_input_irq_o <= accumulator_flags[`TPA_FLAG_IN]
                                 & accumulator_control[`TPA_CTRL_IN_IRQ];
      port_pin_o <= next_pin_out;
      port_pin_oe_o <= next_pin_oe;
      pin_meta <= port_pin_i;
      pin_sync <= pin_meta;
    end
  end

endmodule // tpa_top
`default_nettype wire

// file: verif/tpa_checker.sv
// Purpose: Port-level assertions for the pulse accumulator block
// Assumes: One clock domain, reset_n_i asynchronous and active low
// Notes: Bound onto tpa_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module tpa_checker (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire timer_enable_i,
  input wire stop_mode_i,
  input wire wait_mode_i,
  input wire wait_stop_bit_i,
  input wire [7:0] compare_output_enable_i,
  input wire [7:0] compare_output_level_i,
  input wire [15:0] counter_value_o,
  input wire [7:0] port_pin_o,
  input wire [7:0] port_pin_oe_o
);
  // All checks on the one system clock, idle in reset
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Bus handshake: one wait state, okay response, narrow data
  taken_wait_a: assert property (hsel_i && htrans_i[1] && hready_i && hreadyout_o |=> !hreadyout_o)
    else $error("accepted access gave no wait state");
  one_wait_a: assert property (!hreadyout_o |=> hreadyout_o)
    else $error("wait state longer than one cycle");
  okay_resp_a: assert property (hresp_o == 1'b0)
    else $error("error response seen");
  upper_zero_a: assert property ($rose(hreadyout_o) |-> hrdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // Enabled compares take over their pins
  cmp_forces_oe_a: assert property (1 |=> (port_pin_oe_o & $past(compare_output_enable_i)) == $past(compare_output_enable_i))
    else $error("compare pin not forced to output");
  cmp_level_a: assert property (1 |=> ((port_pin_o ^ $past(compare_output_level_i)) & $past(compare_output_enable_i)) == 8'h00)
    else $error("compare pin level not from timer");
  // Halted counter holds its value
  stop_hold_a: assert property (stop_mode_i [*3] |-> $stable(counter_value_o))
    else $error("counter moved in stop mode");
  ten_hold_a: assert property (!timer_enable_i [*3] |-> $stable(counter_value_o))
    else $error("counter moved with timer disabled");
  wait_hold_a: assert property ((wait_mode_i && wait_stop_bit_i) [*3] |-> $stable(counter_value_o))
    else $error("counter moved in stopped wait");
endmodule // tpa_checker
bind tpa_top tpa_checker u_tpa_chk (.sys_clk_i, .reset_n_i, .hsel_i, .htrans_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .timer_enable_i, .stop_mode_i, .wait_mode_i, .wait_stop_bit_i,
  .compare_output_enable_i, .compare_output_level_i, .counter_value_o, .port_pin_o, .port_pin_oe_o);
`default_nettype wire

// file: verif/tpa_pin_model.sv
// Purpose: Far-side model of the timer port pins
// Assumes: Block output enable is high while it drives a pin
// Notes: Undriven pins carry the level the bench asks for
`timescale 1ns/1ps
`default_nettype none
module tpa_pin_model (
  input wire [7:0] drive_lvl_i,
  input wire [7:0] pin_out_i,
  input wire [7:0] pin_oe_i,
  output wire [7:0] pin_o
);
  // Wire level: block driver where enabled, outside source elsewhere
  assign pin_o = (pin_out_i & pin_oe_i) | (drive_lvl_i & ~pin_oe_i);
endmodule // tpa_pin_model
`default_nettype wire

// file: verif/timer_pulse_accumulator_tb.sv
// Purpose: Self-checking bench for the pulse accumulator block
// Assumes: One wait state per bus access; pins resolved by tpa_pin_model
// Notes: Random counts and data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "tpa_map.vh"
module timer_pulse_accumulator_tb;
  logic clk, rst_n, wr, pt, dt, timer_enable, ffc, smn, stp, wt, dbg, dsb, wsb, h;
  logic [1:0] tr, ccs, cev;
  logic [11:0] adr;
  logic [31:0] wd, rd;
  logic [7:0] coe, clv, ext, d, e, c;
  wire [31:0] rdata;
  wire rdy, ovf_irq, in_irq;
  wire [15:0] cnt;
  wire [1:0] cm;
  wire [7:0] pin, pout, poe;
  int bad_count, num_checks, seed, cyc, hits, h0, i, k, expc;
  logic [7:0] regs [8] = '{`TPA_IDX_CH6, `TPA_IDX_CH7, `TPA_IDX_ACC_CTRL, `TPA_IDX_ACC_FLAGS,
    `TPA_IDX_ACC_COUNT, `TPA_IDX_TEST, `TPA_IDX_PORT_DATA, `TPA_IDX_PORT_DIR};
  // Mode table: stop, wait-stop, debug-stop, wait, debug
  logic [5:0] modes [5] = '{6'b010000, 6'b001100, 6'b000011, 6'b101000, 6'b100010};
  tpa_top DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .hsel_i(1'b1), .haddr_i(adr), .htrans_i(tr),
    .hwrite_i(wr), .hsize_i(3'b010), .hwdata_i(wd), .hready_i(rdy), .hrdata_o(rdata),
    .hreadyout_o(rdy), .hresp_o(), .prescaler_tick_i(pt), .div64_tick_i(dt), .timer_enable_i(timer_enable),
    .fast_flag_clear_i(ffc), .capture_compare_select_i(ccs), .capture_event_i(cev),
    .compare_output_enable_i(coe), .compare_output_level_i(clv), .special_mode_n_i(smn),
    .stop_mode_i(stp), .wait_mode_i(wt), .debug_mode_i(dbg), .debug_stop_bit_i(dsb),
    .wait_stop_bit_i(wsb), .counter_value_o(cnt), .compare_match_o(cm),
    .accumulator_overflow_irq_o(ovf_irq), .accumulator_input_irq_o(in_irq),
    .port_pin_i(pin), .port_pin_o(pout), .port_pin_oe_o(poe));
  tpa_pin_model u_pins (.drive_lvl_i(ext), .pin_out_i(pout), .pin_oe_i(poe), .pin_o(pin));
  // 40 MHz clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results;
    end
  end
  // Count channel 6 compare pulses
  always @(posedge clk) begin
    if (cm[0] === 1'b1) hits <= hits + 1;
  end
  task results;
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready as sampled at the coming rising edge
  task wait_rdy;
    do begin
      @(posedge clk);
      h = rdy;
      rd = rdata;
    end while (h !== 1'b1);
  endtask
  // One whole-word transfer
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] v);
    adr <= {2'b00, idx, 2'b00};
    wr <= w;
    tr <= 2'b10;
    wait_rdy;
    tr <= 2'b00;
    wd <= v;
    wait_rdy;
  endtask
  task rchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(0, idx, 0);
    chk(rd, exp);
  endtask
  // Pin 7 level held well past the synchronizer
  task pin7(input logic v);
    ext[7] <= v;
    repeat (4) @(posedge clk);
  endtask
  task tick(input logic div, input int n);
    repeat (n) begin
      if (div) dt <= 1;
      else pt <= 1;
      @(posedge clk);
      dt <= 0;
      pt <= 0;
      @(posedge clk);
    end
  endtask
  function automatic logic [7:0] port_exp(input logic [7:0] dat, dir, ce, cl, pv);
    logic [7:0] oe, drv;
    oe = dir | ce;
    drv = (cl & ce) | (dat & ~ce);
    return (drv & oe) | (pv & ~oe);
  endfunction
  initial begin
    {rst_n, wr, pt, dt, timer_enable, ffc, stp, wt, dbg, dsb, wsb, tr, ccs, cev, coe, clv, ext, adr, wd} = 0;
    smn = 1;
    seed = 70940;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (regs[j]) rchk(regs[j], 0);
    bus(1, 8'h90, 32'hFFFF_FFFF);
    rchk(8'h90, 0);
    k = 3 + ($random(seed) & 7);
    bus(1, `TPA_IDX_CH6, k);
    rchk(`TPA_IDX_CH6, 0);
    ccs <= 2'b11;
    bus(1, `TPA_IDX_CH6, k);
    rchk(`TPA_IDX_CH6, k);
    // Accumulator off: clock select ignored, prescaler drives counter
    bus(1, `TPA_IDX_ACC_CTRL, 8'h04);
    timer_enable <= 1;
    h0 = hits;
    tick(0, k + 2);
    repeat (3) @(posedge clk);
    expc = k + 2;
    chk(cnt, expc);
    chk(hits - h0, 1);
    // Capture is frozen while the timer is disabled
    timer_enable <= 0;
    ccs <= 2'b01;
    @(posedge clk);
    cev <= 2'b10;
    @(posedge clk);
    cev <= 0;
    rchk(`TPA_IDX_CH7, 0);
    timer_enable <= 1;
    cev <= 2'b10;
    @(posedge clk);
    cev <= 0;
    rchk(`TPA_IDX_CH7, expc);
    // Event counting on both edge settings, counter fed by accumulator clock
    for (i = 0; i < 2; i++) begin
      bus(1, `TPA_IDX_ACC_CTRL, 8'h47 | (i << 4));
      pin7(~i[0]);
      bus(1, `TPA_IDX_ACC_COUNT, 0);
      bus(1, `TPA_IDX_ACC_FLAGS, 3);
      k = 2 + ($random(seed) & 3);
      repeat (k) begin
        pin7(i[0]);
        pin7(~i[0]);
      end
      expc += k;
      rchk(`TPA_IDX_ACC_COUNT, k);
      chk(cnt, expc);
      chk(in_irq, 1);
      rchk(`TPA_IDX_ACC_FLAGS, 1);
      bus(1, `TPA_IDX_ACC_FLAGS, 2);
      rchk(`TPA_IDX_ACC_FLAGS, 1);
      bus(1, `TPA_IDX_ACC_FLAGS, 1);
      rchk(`TPA_IDX_ACC_FLAGS, 0);
    end
    // Wrap from all ones
    bus(1, `TPA_IDX_ACC_COUNT, 32'h0000_FFFF);
    pin7(1);
    // Accumulator clock still feeds the main counter
    expc++;
    rchk(`TPA_IDX_ACC_FLAGS, 3);
    chk(ovf_irq, 1);
    bus(1, `TPA_IDX_ACC_CTRL, 8'h55);
    @(posedge clk);
    chk(ovf_irq, 0);
    ffc <= 1;
    rchk(`TPA_IDX_ACC_COUNT, 0);
    rchk(`TPA_IDX_ACC_FLAGS, 0);
    ffc <= 0;
    // Gated accumulation, no div64 clock while timer is off
    bus(1, `TPA_IDX_ACC_CTRL, 8'h60);
    bus(1, `TPA_IDX_ACC_COUNT, 0);
    timer_enable <= 0;
    tick(1, 3);
    timer_enable <= 1;
    k = 1 + ($random(seed) & 7);
    tick(1, k);
    pin7(0);
    rchk(`TPA_IDX_ACC_COUNT, k);
    rchk(`TPA_IDX_ACC_FLAGS, 1);
    // Test register and split accumulator
    bus(1, `TPA_IDX_TEST, 3);
    rchk(`TPA_IDX_TEST, 0);
    smn <= 0;
    bus(1, `TPA_IDX_TEST, 1);
    rchk(`TPA_IDX_TEST, 1);
    bus(1, `TPA_IDX_ACC_CTRL, 8'h40);
    bus(1, `TPA_IDX_ACC_FLAGS, 3);
    // Both halves step together; high half wrap is the overflow
    bus(1, `TPA_IDX_ACC_COUNT, 32'h0000_FF00);
    pin7(1);
    pin7(0);
    rchk(`TPA_IDX_ACC_COUNT, 32'h0000_0001);
    rchk(`TPA_IDX_ACC_FLAGS, 3);
    bus(1, `TPA_IDX_TEST, 0);
    smn <= 1;
    // Port latch, direction and compare override
    d = $random(seed);
    e = $random(seed);
    c = $random(seed);
    clv <= c;
    coe <= 8'h30;
    ext <= e;
    bus(1, `TPA_IDX_PORT_DIR, 8'h0F);
    bus(1, `TPA_IDX_PORT_DATA, d);
    rchk(`TPA_IDX_PORT_DATA, port_exp(d, 8'h0F, 8'h30, c, e));
    chk(poe, 8'h3F);
    chk(pout & 8'h3F, port_exp(d, 8'h0F, 8'h30, c, 8'h00));
    coe <= 0;
    repeat (3) @(posedge clk);
    chk(poe, 8'h0F);
    // Low-power and debug modes
    bus(1, `TPA_IDX_ACC_CTRL, 0);
    foreach (modes[j]) begin
      {stp, wt, wsb, dbg, dsb} <= modes[j][4:0];
      repeat (2) @(posedge clk);
      tick(0, 3);
      expc += modes[j][5] ? 3 : 0;
      chk(cnt, expc);
    end
    // Counter bypass: both halves advance by the same amount
    smn <= 0;
    bus(1, `TPA_IDX_TEST, 2);
    bus(1, `TPA_IDX_TEST, 0);
    d = cnt[7:0] - cnt[15:8];
    chk(d, expc[7:0]);
    chk(cnt[15:8] != 8'h00, 1);
    results;
  end
endmodule // timer_pulse_accumulator_tb
`default_nettype wire
